// ==== rtl/emr_map.svh ====
`ifndef EMR_MAP_SVH
`define EMR_MAP_SVH

// Bus geometry
`define EMR_ADDR_W         8
`define EMR_DATA_W         32

// Register byte offsets
`define EMR_OFF_FLAGS      8'h00
`define EMR_OFF_IRQ_EN     8'h04
`define EMR_OFF_MGMT       8'h08
`define EMR_OFF_ADDR_HI    8'h0C
`define EMR_OFF_ADDR_LO    8'h10
`define EMR_OFF_RX_LEN     8'h14
`define EMR_OFF_LINK       8'h18

// Event and enable bit positions
`define EMR_BIT_BAD_CARR   0
`define EMR_BIT_WAKE       1
`define EMR_BIT_LINK_CHG   2
`define EMR_FLAG_W         3

// Management pin register bit positions
`define EMR_BIT_MDC        0
`define EMR_BIT_DIR        1
`define EMR_BIT_DOUT       2
`define EMR_BIT_DIN        3
`define EMR_MGMT_W         4

// Field widths
`define EMR_ADDR_LO_W      16
`define EMR_RX_LEN_W       12

// Reset values
`define EMR_RST_FLAGS      3'h0
`define EMR_RST_IRQ_EN     3'h0
`define EMR_RST_MGMT       3'h0
`define EMR_RST_ADDR_HI    32'h0000_0000
`define EMR_RST_ADDR_LO    16'h0000
`define EMR_RST_RX_LEN     12'h000

// Receive length decode
`define EMR_LEN_MIN_CODE   12'h05EE
`define EMR_LEN_MAX_CODE   12'h0800
`define EMR_LEN_MIN_BYTES  12'h05EE
`define EMR_LEN_MAX_BYTES  12'h0800

// Synchroniser depth and link settle count
`define EMR_SYNC_STAGES    2
`define EMR_SETTLE_CNT     2'h3

`endif

// ==== rtl/emr_pkg.sv ====
package emr_pkg;

   typedef logic [31:0] emr_word_t;
   typedef logic [2:0]  emr_flag_t;
   typedef logic [11:0] emr_len_t;

   typedef enum logic [1:0] {
      EMR_PH_IDLE,
      EMR_PH_SETUP,
      EMR_PH_ACCESS
   } emr_phase_e;

endpackage

// ==== rtl/emr_sync.sv ====
`timescale 1ns/1ps
`include "emr_map.svh"

module emr_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_r;

   // Two stage capture, first stage feeds only the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= '0;
         sync_o <= '0;
      end else begin
         meta_r <= async_i;
         sync_o <= meta_r;
      end
   end

endmodule // emr_sync

// ==== rtl/emr_top.sv ====
`timescale 1ns/1ps
`include "emr_map.svh"
// Operation
// - Each status flag drives interrupt only when its enable bit is set
// - Interrupt enable register bits 31 to 3 read as zero
// - Management data-in bit 3 returns the MDIO level after the two stage synchroniser
// - Data-out bit drives MDIO only while direction bit is one
// - Direction bit zero reads from PHY, one writes; resets to zero
// - Management clock bit drives the MDC pin directly
// - Management pin register bits 31 to 4 read as zero
// - Address high register holds address bits 47 to 16, resets zero
// - Address low register holds address bits 15 to 0, resets zero
// - Address low register bits 31 to 16 read as zero
// - First address octet sits in high bits 31 to 24, big-endian
// - Length code maps to 1518 to 2048 bytes, clamped at both ends
// - Interrupt raised for set enabled flag; flag cleared by writing one

module emr_top (
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [`EMR_ADDR_W-1:0]     paddr,
   input  wire logic [`EMR_DATA_W-1:0]     pwdata,
   output emr_pkg::emr_word_t              prdata,
   output logic                            pready,
   output logic                            pslverr,
   output logic                            mdc_o,
   input  wire logic                       mdio_i,
   output logic                            mdio_o,
   output logic                            mdio_oe,
   input  wire logic                       link_sts_i,
   input  wire logic                       bad_carrier_i,
   input  wire logic                       wake_packet_evt_i,
   output logic                            irq_o,
   output logic [47:0]                     station_addr_o,
   output emr_pkg::emr_len_t               rx_max_len_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   emr_pkg::emr_flag_t            flag_r;
   emr_pkg::emr_flag_t            flag_nxt;
   emr_pkg::emr_flag_t            flag_set;
   emr_pkg::emr_flag_t            flag_clr;
   emr_pkg::emr_flag_t            irq_en_r;
   logic [2:0]                    mgmt_r;
   logic [31:0]                   addr_hi_r;
   logic [`EMR_ADDR_LO_W-1:0]     addr_lo_r;
   emr_pkg::emr_len_t             rx_len_r;
   emr_pkg::emr_word_t            prdata_r;
   emr_pkg::emr_word_t            rd_word;
   logic [2:0]                    pin_sync;
   logic                          link_q_r;
   logic [1:0]                    settle_r;
   logic                          carrier_q_r;
   logic                          setup_ph;
   logic                          access_ph;
   logic                          wr_en;
   logic                          mapped;

   ////////////////////////////////////////////////////////////////////////////
   // Functions

   function automatic logic emr_hit(input logic [`EMR_ADDR_W-1:0] a,
                                    input logic [`EMR_ADDR_W-1:0] off);
      emr_hit = (a == off);
   endfunction

   function automatic emr_pkg::emr_len_t emr_len_decode(input emr_pkg::emr_len_t code);
      if (code <= `EMR_LEN_MIN_CODE) begin
         emr_len_decode = `EMR_LEN_MIN_BYTES;
      end else if (code >= `EMR_LEN_MAX_CODE) begin
         emr_len_decode = `EMR_LEN_MAX_BYTES;
      end else begin
         emr_len_decode = code;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   emr_sync #(
      .WIDTH   (3)
   ) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .async_i ({bad_carrier_i, link_sts_i, mdio_i}),
      .sync_o  (pin_sync)
   );

   ////////////////////////////////////////////////////////////////////////////
   // APB slave

   assign setup_ph  = psel && !penable;
   assign access_ph = psel && penable;
   assign wr_en     = access_ph && pwrite;
   assign pready    = 1'b1;
   assign mapped    = emr_hit(paddr, `EMR_OFF_FLAGS)   || emr_hit(paddr, `EMR_OFF_IRQ_EN)  ||
                      emr_hit(paddr, `EMR_OFF_MGMT)    || emr_hit(paddr, `EMR_OFF_ADDR_HI) ||
                      emr_hit(paddr, `EMR_OFF_ADDR_LO) || emr_hit(paddr, `EMR_OFF_RX_LEN)  ||
                      emr_hit(paddr, `EMR_OFF_LINK);
   assign pslverr   = access_ph && !mapped;
   assign prdata    = prdata_r;

   // Read mux, unused bits read as zero
   always_comb begin
      rd_word = '0;
      if (emr_hit(paddr, `EMR_OFF_FLAGS)) begin
         rd_word[`EMR_FLAG_W-1:0] = flag_r;
      end
      if (emr_hit(paddr, `EMR_OFF_IRQ_EN)) begin
         rd_word[`EMR_FLAG_W-1:0] = irq_en_r;
      end
      if (emr_hit(paddr, `EMR_OFF_MGMT)) begin
         rd_word[`EMR_MGMT_W-1:0] = {pin_sync[0], mgmt_r};
      end
      if (emr_hit(paddr, `EMR_OFF_ADDR_HI)) begin
         rd_word = addr_hi_r;
      end
      if (emr_hit(paddr, `EMR_OFF_ADDR_LO)) begin
         rd_word[`EMR_ADDR_LO_W-1:0] = addr_lo_r;
      end
      if (emr_hit(paddr, `EMR_OFF_RX_LEN)) begin
         rd_word[`EMR_RX_LEN_W-1:0] = rx_len_r;
      end
      if (emr_hit(paddr, `EMR_OFF_LINK)) begin
         rd_word[0] = link_q_r;
      end
   end

   // Read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= '0;
      end else if (setup_ph && !pwrite) begin
         prdata_r <= rd_word;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control registers

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_en_r <= `EMR_RST_IRQ_EN;
      end else if (wr_en && emr_hit(paddr, `EMR_OFF_IRQ_EN)) begin
         irq_en_r <= pwdata[`EMR_FLAG_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mgmt_r <= `EMR_RST_MGMT;
      end else if (wr_en && emr_hit(paddr, `EMR_OFF_MGMT)) begin
         mgmt_r <= pwdata[2:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_hi_r <= `EMR_RST_ADDR_HI;
      end else if (wr_en && emr_hit(paddr, `EMR_OFF_ADDR_HI)) begin
         addr_hi_r <= pwdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_lo_r <= `EMR_RST_ADDR_LO;
      end else if (wr_en && emr_hit(paddr, `EMR_OFF_ADDR_LO)) begin
         addr_lo_r <= pwdata[`EMR_ADDR_LO_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_len_r <= `EMR_RST_RX_LEN;
      end else if (wr_en && emr_hit(paddr, `EMR_OFF_RX_LEN)) begin
         rx_len_r <= pwdata[`EMR_RX_LEN_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Management pins

   assign mdc_o   = mgmt_r[`EMR_BIT_MDC];
   assign mdio_o  = mgmt_r[`EMR_BIT_DOUT];
   assign mdio_oe = mgmt_r[`EMR_BIT_DIR];

   ////////////////////////////////////////////////////////////////////////////
   // Station address and length

   assign station_addr_o = {addr_hi_r, addr_lo_r};
   assign rx_max_len_o   = emr_len_decode(rx_len_r);

   ////////////////////////////////////////////////////////////////////////////
   // Event detection

   // Link level tracked silently until synchronisers settle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         settle_r <= '0;
      end else if (settle_r != `EMR_SETTLE_CNT) begin
         settle_r <= settle_r + 2'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link_q_r    <= 1'b0;
         carrier_q_r <= 1'b0;
      end else begin
         link_q_r    <= pin_sync[1];
         carrier_q_r <= pin_sync[2];
      end
   end

   always_comb begin
      flag_set                    = '0;
      flag_set[`EMR_BIT_LINK_CHG] = (settle_r == `EMR_SETTLE_CNT) && (pin_sync[1] != link_q_r);
      flag_set[`EMR_BIT_WAKE]     = wake_packet_evt_i;
      flag_set[`EMR_BIT_BAD_CARR] = (settle_r == `EMR_SETTLE_CNT) && pin_sync[2] && !carrier_q_r;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky flags and interrupt

   assign flag_clr = (wr_en && emr_hit(paddr, `EMR_OFF_FLAGS)) ?
                     pwdata[`EMR_FLAG_W-1:0] : '0;
   assign flag_nxt = (flag_r & ~flag_clr) | flag_set;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_r <= `EMR_RST_FLAGS;
      end else begin
         flag_r <= flag_nxt;
      end
   end

   assign irq_o = |(flag_r & irq_en_r);

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_rd(logic [`EMR_ADDR_W-1:0] off);
      setup_ph && !pwrite && (paddr == off);
   endsequence

   sequence s_wr(logic [`EMR_ADDR_W-1:0] off);
      wr_en && (paddr == off);
   endsequence

   property p_irq_gate;
      s_wr(`EMR_OFF_IRQ_EN) && (pwdata[`EMR_FLAG_W-1:0] == 3'h0) |=> !irq_o;
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("Interrupt raised without an enabled flag");

   property p_irq_en_rsvd;
      s_rd(`EMR_OFF_IRQ_EN) |=> (prdata[31:3] == 29'h0) && (prdata[2:0] == $past(irq_en_r));
   endproperty
   a_irq_en_rsvd: assert property (p_irq_en_rsvd)
      else $error("Enable register read wrong");

   property p_mdio_in;
      s_rd(`EMR_OFF_MGMT) |=> prdata[`EMR_BIT_DIN] == $past(mdio_i, 3);
   endproperty
   a_mdio_in: assert property (p_mdio_in)
      else $error("Data-in bit does not follow MDIO");

   property p_mdio_out;
      s_wr(`EMR_OFF_MGMT) |=> (mdio_o == $past(pwdata[2])) [*2];
   endproperty
   a_mdio_out: assert property (p_mdio_out)
      else $error("MDIO output does not follow data-out bit");

   property p_mdio_dir;
      s_wr(`EMR_OFF_MGMT) ##1 !wr_en |-> mdio_oe == $past(pwdata[1], 1);
   endproperty
   a_mdio_dir: assert property (p_mdio_dir)
      else $error("MDIO enable does not follow direction bit");

   property p_mdc;
      s_wr(`EMR_OFF_MGMT) |=> mdc_o == $past(pwdata[0]);
   endproperty
   a_mdc: assert property (p_mdc)
      else $error("MDC does not follow clock bit");

   property p_mgmt_rsvd;
      s_rd(`EMR_OFF_MGMT) |=> prdata[31:4] == 28'h0;
   endproperty
   a_mgmt_rsvd: assert property (p_mgmt_rsvd)
      else $error("Management register upper bits not zero");

   property p_addr_hi;
      s_wr(`EMR_OFF_ADDR_HI) |=> station_addr_o[47:16] == $past(pwdata);
   endproperty
   a_addr_hi: assert property (p_addr_hi)
      else $error("Address high not stored");

   property p_addr_lo;
      s_wr(`EMR_OFF_ADDR_LO) |=> station_addr_o[15:0] == $past(pwdata[15:0]);
   endproperty
   a_addr_lo: assert property (p_addr_lo)
      else $error("Address low not stored");

   property p_addr_lo_rsvd;
      s_rd(`EMR_OFF_ADDR_LO) |=> prdata[31:16] == 16'h0;
   endproperty
   a_addr_lo_rsvd: assert property (p_addr_lo_rsvd)
      else $error("Address low upper bits not zero");

   property p_first_octet;
      s_wr(`EMR_OFF_ADDR_HI) |=> station_addr_o[47:40] == $past(pwdata[31:24]);
   endproperty
   a_first_octet: assert property (p_first_octet)
      else $error("First octet misplaced");

   property p_len_range;
      (rx_max_len_o >= 12'h05EE) && (rx_max_len_o <= 12'h0800) &&
      ((rx_len_r > 12'h05EE && rx_len_r < 12'h0800) -> (rx_max_len_o == rx_len_r));
   endproperty
   a_len_range: assert property (p_len_range)
      else $error("Frame length decode wrong");

   property p_set_wins;
      wake_packet_evt_i |=> flag_r[`EMR_BIT_WAKE];
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("Wake event lost");

   property p_w1c;
      s_wr(`EMR_OFF_FLAGS) && pwdata[`EMR_BIT_WAKE] && !wake_packet_evt_i
         |=> !flag_r[`EMR_BIT_WAKE];
   endproperty
   a_w1c: assert property (p_w1c)
      else $error("Flag not cleared by writing one");

   property p_sync_depth;
      $changed(mdio_i) ##1 1'b1 |-> pin_sync[0] == $past(mdio_i, 2);
   endproperty
   a_sync_depth: assert property (p_sync_depth)
      else $error("MDIO synchroniser depth wrong");

   c_irq_fire:  cover property (flag_set[`EMR_BIT_LINK_CHG] ##1 irq_o);
   c_mdio_rd:   cover property (s_rd(`EMR_OFF_MGMT) ##1 !mdio_oe);
   c_mdc_pulse: cover property ($rose(mdc_o) ##[1:20] $fell(mdc_o));
   c_len_mid:   cover property (rx_len_r == 12'h0600);

endmodule // emr_top

// ==== testbench/emr_phy_model.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Management side of the PHY: records written bits, serves read bits
module emr_phy_model (
   input  wire logic        mdc,
   input  wire logic        mdio_o,
   input  wire logic        mdio_oe,
   input  wire logic        drive_en,
   input  wire logic [15:0] rd_word,
   output logic             phy_oe,
   output logic             phy_val,
   output logic [15:0]      wr_bits
);
   logic [15:0] sh;

   initial begin
      wr_bits = 16'h0000;
      sh      = 16'h0000;
   end

   // Drive only while the host has released the line
   assign phy_oe  = drive_en & ~mdio_oe;
   assign phy_val = sh[15];

   always @(posedge drive_en) begin
      sh = rd_word;
   end

   // Host data taken at rising clock; read data moves on after it
   always @(posedge mdc) begin
      if (mdio_oe) begin
         wr_bits <= {wr_bits[14:0], mdio_o};
      end else if (drive_en) begin
         sh <= {sh[14:0], 1'b0};
      end
   end
endmodule // emr_phy_model

// ==== testbench/emr_irq_mii_addr_regs_tb_top.sv ====
`timescale 1ns/1ps
`include "emr_map.svh"
module emr_irq_mii_addr_regs_tb_top;
   logic                pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic                mdc_o, mdio_o, mdio_oe, irq_o, mdio_line, phy_oe, phy_val;
   logic                link_sts_i, bad_carrier_i, wake_packet_evt_i, phy_drv, err;
   logic [7:0]          paddr;
   logic [31:0]         pwdata, rd, m_flag, m_en, m_mg, m_hi, m_lo, m_len, v;
   logic [15:0]         phy_rd, phy_got;
   logic [47:0]         station_addr_o;
   emr_pkg::emr_word_t  prdata;
   emr_pkg::emr_len_t   rx_max_len_o;
   int                  err_count, check_count, seed;
   logic [7:0]          rw_off [4] = '{8'h04, 8'h0C, 8'h10, 8'h14};
   logic [11:0]         len_code [6] = '{12'h000, 12'h5EE, 12'h5EF, 12'h7FF, 12'h800, 12'hFFF};

   // Wire level: device, then PHY, else pull-up
   assign mdio_line = mdio_oe ? mdio_o : (phy_oe ? phy_val : 1'b1);

   emr_top u_emr_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mdc_o(mdc_o), .mdio_i(mdio_line), .mdio_o(mdio_o),
      .mdio_oe(mdio_oe), .link_sts_i(link_sts_i), .bad_carrier_i(bad_carrier_i),
      .wake_packet_evt_i(wake_packet_evt_i), .irq_o(irq_o),
      .station_addr_o(station_addr_o), .rx_max_len_o(rx_max_len_o));

   emr_phy_model u_emr_phy_model (.mdc(mdc_o), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
      .drive_en(phy_drv), .rd_word(phy_rd), .phy_oe(phy_oe), .phy_val(phy_val),
      .wr_bits(phy_got));

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   initial begin
      #3_000_000;
      err_count++;
      wrap_up();
   end

   ////////////////////////////////////////////////////////////////////////////////
   task wrap_up;
      if (err_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task chk(input string nm, input logic [47:0] e, input logic [47:0] g);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask

   function automatic logic [11:0] len_of(input logic [31:0] c);
      int b;
      b = c[11:0];
      b = (b < 1518) ? 1518 : ((b > 2048) ? 2048 : b);
      return 12'(b);
   endfunction

   function automatic logic [31:0] exp_rd(input logic [7:0] a);
      case (a)
         8'h00:   return m_flag;
         8'h04:   return m_en;
         8'h08:   return {28'h000_0000, mdio_line, m_mg[2:0]};
         8'h0C:   return m_hi;
         8'h10:   return m_lo;
         8'h14:   return m_len;
         8'h18:   return {31'h0000_0000, link_sts_i};
         default: return 32'h0000_0000;
      endcase
   endfunction

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      chk("pready", 1, pready);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      case (a)
         8'h00: m_flag = m_flag & ~(d & 32'h0000_0007);
         8'h04: m_en = d & 32'h0000_0007;
         8'h08: m_mg = d & 32'h0000_0007;
         8'h0C: m_hi = d;
         8'h10: m_lo = d & 32'h0000_FFFF;
         8'h14: m_len = d & 32'h0000_0FFF;
         default: ;
      endcase
      @(negedge pclk);
   endtask

   task rdchk(input logic [7:0] a);
      apb(1'b0, a, 32'h0000_0000);
      chk($sformatf("reg_%h", a), exp_rd(a), rd);
      chk("pslverr", 0, err);
   endtask

   task check_all;
      for (int i = 0; i < 7; i++) rdchk(8'(i * 4));
      chk("station_addr", {m_hi, m_lo[15:0]}, station_addr_o);
      chk("rx_max_len", len_of(m_len), rx_max_len_o);
   endtask

   task event_hit(input int b);
      @(posedge pclk);
      if (b == 0) bad_carrier_i <= 1'b1;
      if (b == 1) wake_packet_evt_i <= 1'b1;
      if (b == 2) link_sts_i <= ~link_sts_i;
      @(posedge pclk);
      wake_packet_evt_i <= 1'b0;
      repeat (5) @(posedge pclk);
      m_flag = m_flag | (32'h1 << b);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {link_sts_i, bad_carrier_i, wake_packet_evt_i, phy_drv, phy_rd} = '0;
      {m_flag, m_en, m_mg, m_hi, m_lo, m_len} = '0;
      err_count = 0;
      check_count = 0;
      seed = 32'h9165;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      check_all();
      // Random fill of the read/write registers except the management pin register
      repeat (4) begin
         foreach (rw_off[i]) begin
            wr(rw_off[i], $random(seed));
         end
         check_all();
      end
      // Length code boundaries
      foreach (len_code[i]) begin
         wr(8'h14, {20'h0_0000, len_code[i]});
         chk("rx_len_code", len_of(m_len), rx_max_len_o);
      end
      // Address is set while nothing transmits or receives
      wr(8'h0C, 32'h0123_4567);
      wr(8'h10, 32'h0000_89AB);
      chk("first_octet", 8'h01, station_addr_o[47:40]);
      chk("last_octet", 8'hAB, station_addr_o[7:0]);
      // Unmapped places answer with an error and keep state
      apb(1'b1, 8'h40, 32'hFFFF_FFFF);
      chk("unmapped_wr_err", 1, err);
      apb(1'b0, 8'h1C, 32'h0000_0000);
      chk("unmapped_rd_err", 1, err);
      chk("unmapped_rd", 0, rd);
      check_all();
      // Every pin register combination
      for (int k = 0; k < 16; k++) begin
         wr(8'h08, 32'(k));
         chk("mdc_o", k[0], mdc_o);
         chk("mdio_oe", k[1], mdio_oe);
         chk("mdio_line", k[1] ? k[2] : 1'b1, mdio_line);
         repeat (3) @(posedge pclk);
         rdchk(8'h08);
      end
      // Bit-banged frame toward the PHY
      v = $random(seed);
      for (int k = 15; k >= 0; k--) begin
         wr(8'h08, {29'h0, v[k], 2'b10});
         wr(8'h08, {29'h0, v[k], 2'b11});
      end
      chk("phy_got", v[15:0], phy_got);
      // Bit-banged frame from the PHY
      phy_rd = 16'($random(seed));
      wr(8'h08, 32'h0000_0000);
      phy_drv = 1'b1;
      for (int k = 15; k >= 0; k--) begin
         repeat (3) @(posedge pclk);
         apb(1'b0, 8'h08, 32'h0000_0000);
         chk("din_bit", phy_rd[k], rd[3]);
         wr(8'h08, 32'h0000_0001);
         wr(8'h08, 32'h0000_0000);
      end
      phy_drv = 1'b0;
      // Events: masked, enabled, write zero, write one
      for (int b = 0; b < 3; b++) begin
         wr(8'h04, 32'h0000_0000);
         event_hit(b);
         rdchk(8'h00);
         chk("irq_masked", 0, irq_o);
         wr(8'h04, 32'h1 << b);
         chk("irq_enabled", 1, irq_o);
         wr(8'h00, 32'h0000_0000);
         chk("irq_wr0", 1, irq_o);
         wr(8'h00, 32'h1 << b);
         chk("irq_cleared", 0, irq_o);
         bad_carrier_i <= 1'b0;
         repeat (6) @(posedge pclk);
         check_all();
      end
      // Wake event in the very cycle of its clearing write: the set wins
      fork
         apb(1'b1, 8'h00, 32'h0000_0002);
         begin
            repeat (2) @(posedge pclk);
            wake_packet_evt_i <= 1'b1;
            @(posedge pclk);
            wake_packet_evt_i <= 1'b0;
         end
      join
      m_flag = 32'h0000_0002;
      rdchk(8'h00);
      wrap_up();
   end
endmodule // emr_irq_mii_addr_regs_tb_top
